// ===== verification/inertial_sensor_spi_read_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module inertial_sensor_spi_read_port_tb
  import isp_pkg::*;
;
  logic        clk_in, rstn_in, start_in, busy_out, done_out;
  logic        drdy_out, sync_clock_in, sync_mode_out, sync_out, sync_oe;
  logic [15:0] cmd_in, rdata_out, sensor_data_in, rd;
  int          n_fail, check_count, c, i;
  isp_link_if  link ();
  isp_device u_isp_device (.clk_in, .rstn_in, .link(link), .sensor_data_in,
    .sync_clock_in, .sync_clock_out(sync_out), .sync_clock_oe_out(sync_oe),
    .sync_mode_out);
  isp_master u_isp_master (.clk_in, .rstn_in, .link(link), .start_in,
    .cmd_in, .busy_out, .done_out, .rdata_out, .drdy_out);
  isp_link_properties u_isp_link_properties (.clk_in, .rstn_in,
    .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi),
    .miso(link.miso), .miso_oe(link.miso_oe), .drdy(link.drdy));
  // Free-running system clock.
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One frame through the master; the received word lands in rd.
  task automatic xfer(input logic [15:0] cmd);
    int n;
    n = 0;
    @(posedge clk_in);
    start_in <= 1'b1;
    cmd_in   <= cmd;
    @(posedge clk_in);
    start_in <= 1'b0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (done_out !== 1'b1 && n < 400);
    if (n >= 400) begin
      n_fail++;
      $display("[FAIL] t=%0t frame hung", $time);
    end
    rd = rdata_out;
    chk({15'h0000, busy_out}, 16'h0000);
  endtask : xfer
  // Waits for a data-ready rise; c is the cycles waited, bounded.
  task automatic wait_drdy(output int cnt);
    logic p, q;
    cnt = 0;
    p = drdy_out;
    do begin
      @(posedge clk_in);
      #1;
      cnt++;
      q = p;
      p = drdy_out;
    end while (!(p === 1'b1 && q === 1'b0) && cnt < 30000);
    chk({15'h0000, cnt < 30000}, 16'h0001);
  endtask : wait_drdy
  // The only place the run ends.
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  // Cuts a hang short; the tests need about 80000 cycles.
  initial begin
    repeat (100000) @(posedge clk_in);
    n_fail++;
    close_out();
  end
  initial begin
    n_fail = 0;
    check_count = 0;
    rstn_in = 1'b0;
    start_in = 1'b0;
    cmd_in = 16'h0000;
    sensor_data_in = 16'h5a3c;
    sync_clock_in = 1'b0;
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    wait_drdy(c);
    wait_drdy(c);
    chk(16'(c), 16'(SAMPLE_CYC));
    chk({14'h0000, sync_oe, sync_out}, 16'h0002);
    $display("test period done");
    xfer(16'h0a00);
    xfer(16'h0b00);
    chk(rd, 16'h5a3c ^ 16'h0005);
    xfer(16'h0000);
    chk(rd, 16'h5a3c ^ 16'h0005);
    // Each frame carries the next address while the last word returns.
    for (i = 1; i <= 12; i++) begin
      xfer({1'b0, 7'(2 * i), 8'h00});
      if (i > 1) chk(rd, 16'h5a3c ^ 16'(i - 1));
    end
    xfer(16'ha0c4);
    chk(rd, 16'h5a3c ^ 16'h000c);
    xfer(16'ha11f);
    xfer(16'h2000);
    xfer(16'h2100);
    chk(rd, 16'h1fc4);
    xfer(16'h0000);
    chk(rd, 16'h1fc4);
    $display("test read write done");
    sensor_data_in <= 16'hc3e1;
    wait_drdy(c);
    xfer(BURST_CMD);
    for (i = 1; i <= 12; i++) begin
      xfer(16'h0000);
      chk(rd, 16'hc3e1 ^ 16'(i));
    end
    $display("test burst done");
    xfer(16'hb201);
    repeat (8) @(posedge clk_in);
    chk({15'h0000, sync_mode_out}, 16'h0001);
    chk({14'h0000, sync_oe, sync_out}, 16'h0000);
    sync_clock_in <= 1'b1;
    wait_drdy(c);
    chk({15'h0000, c < 200}, 16'h0001);
    $display("test sync done");
    close_out();
  end
endmodule : inertial_sensor_spi_read_port_tb
`default_nettype wire

// ===== verification/isp_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module isp_link_properties
  import isp_pkg::*;
(
  input wire logic clk_in,  // System clock.
  input wire logic rstn_in, // Synchronous reset, active low.
  input wire logic sclk,    // Serial clock.
  input wire logic cs_n,    // Chip select, active low.
  input wire logic mosi,    // Data into the device.
  input wire logic miso,    // Data out of the device.
  input wire logic miso_oe, // Device output enable.
  input wire logic drdy     // Data-ready pulse.
);
  logic [4:0]  bits_r, bits_nxt; // Serial clock rises in this frame.
  logic [15:0] gap_r, gap_nxt;   // Cycles since the last data-ready rise.
  logic        sclk_q_r;         // Serial clock one cycle ago.
  logic        drdy_q_r;         // Data ready one cycle ago.
  // A high select clears the count, as the device must do.
  always_comb begin
    bits_nxt = cs_n ? 5'h00 : bits_r + {4'h0, sclk & ~sclk_q_r};
    gap_nxt  = (drdy & ~drdy_q_r) ? 16'h0001 : gap_r + 16'h0001;
  end
  // Registers only; the next values come from above.
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      bits_r   <= 5'h00;
      gap_r    <= 16'h0000;
      sclk_q_r <= 1'b1;
      drdy_q_r <= 1'b0;
    end else begin
      bits_r   <= bits_nxt;
      gap_r    <= gap_nxt;
      sclk_q_r <= sclk;
      drdy_q_r <= drdy;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // Steps of a frame (lead-in, low half), and the data-ready pulse.
  sequence s_lead; sclk[*5] ##1 !sclk; endsequence
  sequence s_low; !sclk[*5] ##1 sclk; endsequence
  sequence s_pulse; drdy[*4] ##1 !drdy; endsequence
  property p_lead; $fell(cs_n) |-> s_lead; endproperty
  property p_half; !cs_n && $fell(sclk) |-> s_low; endproperty
  property p_pulse; $rose(drdy) |-> s_pulse; endproperty
  property p_idle; cs_n |-> sclk; endproperty
  property p_oe_off; cs_n[*5] |-> !miso_oe; endproperty
  property p_bits; $rose(cs_n) |-> bits_r == 5'h10; endproperty
  property p_mosi; !cs_n && $rose(sclk) |-> $stable(mosi)[*3]; endproperty
  property p_miso;
    !cs_n && sclk && $past(sclk) && miso_oe && $past(miso_oe)
      |-> $stable(miso);
  endproperty
  // A slack of three cycles allows for the sync path latency.
  property p_gap; gap_r <= 16'(SAMPLE_CYC + 3); endproperty
  a_lead: assert property (p_lead)
    else $error("clock lead-in after select wrong");
  a_half: assert property (p_half)
    else $error("clock low half wrong");
  a_pulse: assert property (p_pulse)
    else $error("data-ready width wrong");
  a_idle: assert property (p_idle)
    else $error("clock not idle high");
  a_oe_off: assert property (p_oe_off)
    else $error("output driven while deselected");
  a_bits: assert property (p_bits)
    else $error("frame not sixteen bits");
  a_mosi: assert property (p_mosi)
    else $error("input moved at rising clock");
  a_miso: assert property (p_miso)
    else $error("output moved while clock high");
  a_gap: assert property (p_gap)
    else $error("sample period overrun");
endmodule : isp_link_properties
`default_nettype wire

// ===== verilog/isp_device.sv
`timescale 1ns/1ps
`default_nettype none
module isp_device
  import isp_pkg::*;
(
  input  wire logic        clk_in,            // System clock.
  input  wire logic        rstn_in,           // Synchronous reset.
  isp_link_if.device       link,              // Serial link.
  input  wire logic [15:0] sensor_data_in,    // Stand-in sample value.
  input  wire logic        sync_clock_in,     // Fourth pin input level.
  output logic             sync_clock_out,    // Fourth pin output level.
  output logic             sync_clock_oe_out, // Fourth pin drive enable.
  output logic             sync_mode_out      // Sync clock mode is active.
);

  // Synchroniser stages for every pin that comes from outside.
  logic [3:0] s1_r, s2_r;
  logic [3:0] s1_nxt;
  // Previous synchronised levels for edge detection.
  logic       sclk_d_r, sync_d_r;
  logic       sclk_s, cs_s, mosi_s, sync_s;
  logic       sclk_rise, sclk_fall, sync_rise;

  // Two flops per pin; only the second stage is looked at.
  always_comb begin
    s1_nxt = {sync_clock_in, link.mosi, link.cs_n, link.sclk};
  end
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      // Idle pin levels: clock and select high, data and sync low.
      // Reset must match them, or a false sync edge follows reset.
      s1_r     <= 4'h3;
      s2_r     <= 4'h3;
      sclk_d_r <= 1'b1;
      sync_d_r <= 1'b0;
    end else begin
      s1_r     <= s1_nxt;
      s2_r     <= s1_r;
      sclk_d_r <= s2_r[0];
      sync_d_r <= s2_r[3];
    end
  end
  assign sclk_s    = s2_r[0];
  assign cs_s      = s2_r[1];
  assign mosi_s    = s2_r[2];
  assign sync_s    = s2_r[3];
  assign sclk_rise = sclk_s & ~sclk_d_r & ~cs_s;
  assign sclk_fall = ~sclk_s & sclk_d_r & ~cs_s;
  assign sync_rise = sync_s & ~sync_d_r;

  // Register map held as words; byte addresses pick a half.
  logic [15:0] map_r [MAP_WORDS];
  logic        sync_sel;

  // Mode select: gpio control bit picks the sync clock function.
  assign sync_sel = map_r[GPIO_CTRL_ADDR[6:1]][SYNC_SEL_BIT];

  // Sample timer and data-ready pulse state.
  // The timer must hold a full sample period of cycles.
  logic [14:0] tmr_r, tmr_nxt;
  logic [2:0]  drdy_r, drdy_nxt;
  logic        smp_tick;

  // Free running timer, or the external sync edge when selected.
  always_comb begin
    tmr_nxt  = tmr_r + 15'h0001;
    smp_tick = 1'b0;
    if (sync_sel) begin
      tmr_nxt  = 15'h0000;
      smp_tick = sync_rise;
    end else if (tmr_r == 15'(SAMPLE_CYC - 1)) begin
      tmr_nxt  = 15'h0000;
      smp_tick = 1'b1;
    end
    drdy_nxt = (drdy_r != 3'h0) ? drdy_r - 3'h1 : 3'h0;
    if (smp_tick) begin
      drdy_nxt = 3'(DRDY_CYC);
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      tmr_r  <= 15'h0000;
      drdy_r <= 3'h0;
    end else begin
      tmr_r  <= tmr_nxt;
      drdy_r <= drdy_nxt;
    end
  end
  // Pulse is seen in the same cycle that the output words have loaded.
  assign link.drdy = (drdy_r != 3'h0);

  // Serial engine state.
  logic [4:0]  cnt_r, cnt_nxt;
  logic [15:0] rx_r, rx_nxt;
  logic [15:0] tx_r, tx_nxt;
  logic        burst_r, burst_nxt;
  logic [6:0]  baddr_r, baddr_nxt;
  logic        miso_r, miso_nxt;
  logic [15:0] word;
  logic        wr_en;
  logic [5:0]  wr_idx;
  logic        wr_hi;
  logic [7:0]  wr_byte;

  // Shift engine: rising edges take in bits, falling edges put out bits.
  always_comb begin
    cnt_nxt   = cnt_r;
    rx_nxt    = rx_r;
    tx_nxt    = tx_r;
    burst_nxt = burst_r;
    baddr_nxt = baddr_r;
    miso_nxt  = miso_r;
    wr_en     = 1'b0;
    word      = {rx_r[14:0], mosi_s};
    wr_idx    = word[ADDR_MSB:ADDR_LSB+1];
    wr_hi     = word[ADDR_LSB];
    wr_byte   = word[7:0];
    if (cs_s) begin
      cnt_nxt  = 5'h00;
      miso_nxt = tx_r[15];
    end else if (sclk_rise) begin
      rx_nxt = word;
      tx_nxt = {tx_r[14:0], 1'b0};
      if (cnt_r == 5'(FRAME_BITS - 1)) begin
        cnt_nxt = 5'h00;
        // Frame complete: load the reply for the next frame.
        if (word[WRITE_BIT]) begin
          wr_en     = 1'b1;
          burst_nxt = 1'b0;
          tx_nxt    = 16'h0000;
        end else if (word == BURST_CMD) begin
          burst_nxt = 1'b1;
          baddr_nxt = BURST_FIRST + 7'h02;
          tx_nxt    = map_r[BURST_FIRST[6:1]];
        end else if (burst_r) begin
          // Burst walks the outputs; command bits are ignored.
          tx_nxt    = map_r[baddr_r[6:1]];
          baddr_nxt = baddr_r + 7'h02;
          burst_nxt = (baddr_r != BURST_LAST);
        end else begin
          // Either byte address of a word returns the whole word.
          tx_nxt = map_r[word[ADDR_MSB:ADDR_LSB+1]];
        end
      end else begin
        cnt_nxt = cnt_r + 5'h01;
      end
    end else if (sclk_fall) begin
      miso_nxt = tx_r[15];
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cnt_r   <= 5'h00;
      rx_r    <= 16'h0000;
      tx_r    <= 16'h0000;
      burst_r <= 1'b0;
      baddr_r <= 7'h00;
      miso_r  <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      rx_r    <= rx_nxt;
      tx_r    <= tx_nxt;
      burst_r <= burst_nxt;
      baddr_r <= baddr_nxt;
      miso_r  <= miso_nxt;
    end
  end
  assign link.miso    = miso_r;
  assign link.miso_oe = ~cs_s;

  // Map storage: outputs load on each sample, bytes load from writes.
  // Output words take a stand-in value; the sensing itself is outside.
  genvar gi;
  generate
    for (gi = 0; gi < MAP_WORDS; gi++) begin : g_map
      always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
          map_r[gi] <= (gi == int'(SAMPLE_PERIOD_ADDR[6:1])) ? 16'h0001
                                                              : 16'h0000;
        end else if (wr_en && wr_idx == 6'(gi)) begin
          if (wr_hi) begin
            map_r[gi][15:8] <= wr_byte;
          end else begin
            map_r[gi][7:0]  <= wr_byte;
          end
        end else if (smp_tick && gi >= int'(BURST_FIRST[6:1])
                     && gi <= int'(BURST_LAST[6:1])) begin
          map_r[gi] <= sensor_data_in ^ 16'(gi);
        end
      end
    end
  endgenerate

  // Fourth pin: driven low as plain output, released as sync input.
  assign sync_clock_out    = 1'b0;
  assign sync_clock_oe_out = ~sync_sel;
  assign sync_mode_out     = sync_sel;

endmodule : isp_device
`default_nettype wire

// ===== verilog/isp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface isp_link_if;
  logic sclk;      // Serial clock from the master, idles high.
  logic cs_n;      // Chip select, active low.
  logic mosi;      // Serial data into the device.
  logic miso;      // Serial data out of the device.
  logic miso_oe;   // High while the device drives the output line.
  logic drdy;      // Data-ready pulse from the device.
  modport device (input sclk, cs_n, mosi, output miso, miso_oe, drdy);
  modport master (input miso, miso_oe, drdy, output sclk, cs_n, mosi);
endinterface : isp_link_if
`default_nettype wire

// ===== verilog/isp_master.sv
`timescale 1ns/1ps
`default_nettype none
module isp_master
  import isp_pkg::*;
(
  input  wire logic        clk_in,      // System clock.
  input  wire logic        rstn_in,     // Synchronous reset.
  isp_link_if.master       link,        // Serial link.
  input  wire logic        start_in,    // Request one frame.
  input  wire logic [15:0] cmd_in,      // Word sent in that frame.
  output logic             busy_out,    // Frame in progress.
  output logic             done_out,    // One-cycle pulse, frame ended.
  output logic [15:0]      rdata_out,   // Word received in that frame.
  output logic             drdy_out     // Synchronised data-ready level.
);

  typedef enum logic [1:0] {
    ISP_IDLE = 2'b00,
    ISP_LEAD = 2'b01,
    ISP_SHFT = 2'b10,
    ISP_TAIL = 2'b11
  } isp_state_t;

  isp_state_t  st_r, st_nxt;
  logic [3:0]  div_r, div_nxt;     // Half period divider.
  logic [4:0]  bit_r, bit_nxt;     // Bits left.
  logic [15:0] tx_r, tx_nxt;
  logic [15:0] rx_r, rx_nxt;
  logic        sclk_r, sclk_nxt;
  logic        cs_r, cs_nxt;
  logic        done_r, done_nxt;
  logic [15:0] rd_r, rd_nxt;
  logic [1:0]  mi_r, dr_r;         // Synchronisers for device pins.
  logic        tick;

  assign tick = (div_r == 4'(SCLK_HALF_CYC - 1));

  // Mode 3 master, 16-bit frames, clock kept at the normal-mode limit.
  always_comb begin
    st_nxt   = st_r;
    div_nxt  = tick ? 4'h0 : div_r + 4'h1;
    bit_nxt  = bit_r;
    tx_nxt   = tx_r;
    rx_nxt   = rx_r;
    sclk_nxt = sclk_r;
    cs_nxt   = cs_r;
    done_nxt = 1'b0;
    rd_nxt   = rd_r;
    unique case (st_r)
      ISP_IDLE: begin
        div_nxt = 4'h0;
        if (start_in) begin
          st_nxt  = ISP_LEAD;
          cs_nxt  = 1'b0;
          tx_nxt  = cmd_in;
          bit_nxt = 5'(FRAME_BITS);
        end
      end
      ISP_LEAD: begin
        if (tick) begin
          // First falling edge: the device puts out its top bit.
          st_nxt   = ISP_SHFT;
          sclk_nxt = 1'b0;
        end
      end
      ISP_SHFT: begin
        if (tick && sclk_r) begin
          // Falling edge: take the device bit, settled through the
          // synchroniser, and move our own bit on for the next rise.
          sclk_nxt = 1'b0;
          rx_nxt   = {rx_r[14:0], mi_r[1]};
          tx_nxt   = {tx_r[14:0], 1'b0};
        end else if (tick) begin
          // Rising edge: the device takes our bit, stable a half period.
          sclk_nxt = 1'b1;
          bit_nxt  = bit_r - 5'h01;
          if (bit_r == 5'h01) begin
            st_nxt = ISP_TAIL;
          end
        end
      end
      ISP_TAIL: begin
        if (tick) begin
          // The last device bit is taken here, before select rises.
          cs_nxt   = 1'b1;
          st_nxt   = ISP_IDLE;
          done_nxt = 1'b1;
          rx_nxt   = {rx_r[14:0], mi_r[1]};
          rd_nxt   = {rx_r[14:0], mi_r[1]};
        end
      end
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      st_r   <= ISP_IDLE;
      div_r  <= 4'h0;
      bit_r  <= 5'h00;
      tx_r   <= 16'h0000;
      rx_r   <= 16'h0000;
      sclk_r <= 1'b1;
      cs_r   <= 1'b1;
      done_r <= 1'b0;
      rd_r   <= 16'h0000;
      mi_r   <= 2'h0;
      dr_r   <= 2'h0;
    end else begin
      st_r   <= st_nxt;
      div_r  <= div_nxt;
      bit_r  <= bit_nxt;
      tx_r   <= tx_nxt;
      rx_r   <= rx_nxt;
      sclk_r <= sclk_nxt;
      cs_r   <= cs_nxt;
      done_r <= done_nxt;
      rd_r   <= rd_nxt;
      mi_r   <= {mi_r[0], link.miso};
      dr_r   <= {dr_r[0], link.drdy};
    end
  end
  assign link.sclk = sclk_r;
  assign link.cs_n = cs_r;
  assign link.mosi = tx_r[15];
  assign busy_out  = (st_r != ISP_IDLE);
  assign done_out  = done_r;
  assign rdata_out = rd_r;
  assign drdy_out  = dr_r[1];

endmodule : isp_master
`default_nettype wire

// ===== verilog/isp_pkg.sv
package isp_pkg;
  // System clock in kHz.
  localparam int unsigned CLK_KHZ            = 20000;
  // Sample rate in tenths of a sample per second.
  localparam int unsigned SAMPLE_RATE_DSPS   = 8192;
  // Cycles per sample period, rounded down.
  localparam int unsigned SAMPLE_CYC         =
    (CLK_KHZ * 10000) / SAMPLE_RATE_DSPS;
  // Width of the data-ready pulse in cycles.
  localparam int unsigned DRDY_CYC           = 4;
  // Frame length in bits.
  localparam int unsigned FRAME_BITS         = 16;
  // Master-side serial clock in kHz (normal mode limit).
  localparam int unsigned SCLK_KHZ           = 2000;
  // Half period of the master serial clock in system cycles.
  localparam int unsigned SCLK_HALF_CYC      = CLK_KHZ / (2 * SCLK_KHZ);
  // Address field of a command frame.
  localparam int unsigned ADDR_MSB           = 14;
  localparam int unsigned ADDR_LSB           = 8;
  // Write flag position.
  localparam int unsigned WRITE_BIT          = 15;
  // Byte address of the x-axis accelerometer output register.
  localparam logic [6:0]  X_ACCEL_ADDR       = 7'h0a;
  // Burst start command word.
  localparam logic [15:0] BURST_CMD          = 16'h3e00;
  // First and last output register addresses for a burst.
  localparam logic [6:0]  BURST_FIRST        = 7'h02;
  localparam logic [6:0]  BURST_LAST         = 7'h18;
  // Sample period setting register and gpio control register addresses.
  localparam logic [6:0]  SAMPLE_PERIOD_ADDR = 7'h36;
  localparam logic [6:0]  GPIO_CTRL_ADDR     = 7'h32;
  // Bit of the gpio control low byte that selects sync clock mode.
  localparam int unsigned SYNC_SEL_BIT       = 0;
  // Number of 16-bit words in the map.
  localparam int unsigned MAP_WORDS          = 64;
endpackage : isp_pkg
